// file: logic/bertei_pkg.sv
// Constants and types for the error insertion and checker status block.
// Assumes a 32-bit APB register bus on pclk and word-indexed registers.
//
// Operation
// [R01] Hold a 32-bit seed or fixed pattern word for transmit and receive.
// [R02] Transmit sends bit 31 of the seed/pattern word first.
// [R03] Receive aligns bit 31 of the pattern word with the first bit received.
// [R04] Rate value n inverts one transmit bit in 10**n; zero disables.
// [R05] Rate insertion starts when the control register gets a nonzero rate.
// [R06] A rate rewritten mid-interval takes effect after the next inserted error.
// [R07] Single error insertion only happens while its enable bit is set.
// [R08] Each rising edge of the register trigger inverts exactly one bit.
// [R09] Several trigger edges between two opportunities insert only one error.
// [R10] Source select picks register trigger (0) or external input (1).
// [R11] Software keeps both triggers low before changing the source select.
// [R12] Update status rises on completed update, falls when trigger goes low.
// [R13] Count-nonzero reads one while errors counted; cleared by an update.
// [R14] Sync-loss status reads one while the checker is out of sync.
// [R15] Latched update flag sets on rising edge of update status.
// [R16] Latched bit-error flag sets on any detected bit error.
// [R17] Latched count flag sets on rising edge of count-nonzero status.
// [R18] Latched sync-loss flag sets on every change of sync-loss status.
// [R19] Update mode picks local (0) or global/port (1) update trigger.
// [R20] Flags request interrupt when enabled; three also need port enable.
// [R21] Latched flags clear only by writing one to their bit.
// [R22] All configuration and enable bits reset to zero.

package bertei_pkg;

	// Register indices; byte address is four times the index.
	localparam logic [9:0] IDX_SEED_LO    = 10'h064;
	localparam logic [9:0] IDX_SEED_HI    = 10'h066;
	localparam logic [9:0] IDX_INS_CTRL   = 10'h068;
	localparam logic [9:0] IDX_STATUS     = 10'h06C;
	localparam logic [9:0] IDX_LATCHED    = 10'h06E;
	localparam logic [9:0] IDX_IRQ_EN     = 10'h070;
	localparam logic [9:0] IDX_UPD_CTRL   = 10'h072;

	// Error insertion control fields.
	localparam int POS_MANUAL_SEL  = 0;
	localparam int POS_SINGLE_TRIG = 1;
	localparam int POS_SINGLE_EN   = 2;
	localparam int POS_RATE_LSB    = 3;

	// Update control fields.
	localparam int POS_LOCAL_UPD = 0;
	localparam int POS_UPD_MODE  = 1;

	localparam logic [15:0] RST_HALF   = 16'h0000;
	localparam logic [23:0] CNT_ZERO   = 24'h000000;
	localparam logic [23:0] CNT_ONE    = 24'h000001;

	// Event bits in status, latched and enable order (bit 3 down to 0).
	typedef struct packed {
		logic update_done;
		logic bit_error;
		logic count_nonzero;
		logic sync_loss;
	} bertei_evt_t;

	localparam bertei_evt_t EVT_NONE = '{1'b0, 1'b0, 1'b0, 1'b0};

	// Interval in bits for a decade rate exponent.
	function automatic logic [23:0] bertei_interval(input logic [2:0] n);
		case (n)
			3'h1:    return 24'h00000A;
			3'h2:    return 24'h000064;
			3'h3:    return 24'h0003E8;
			3'h4:    return 24'h002710;
			3'h5:    return 24'h0186A0;
			3'h6:    return 24'h0F4240;
			3'h7:    return 24'h989680;
			default: return CNT_ZERO;
		endcase
	endfunction : bertei_interval

endpackage : bertei_pkg

// file: logic/bertei_sync2.sv
// Two-stage synchroniser for a level arriving from a pin.
// Assumes the level is slow compared with pclk.
`timescale 1ns/1ps

module bertei_sync2 (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Level
	input  wire logic async_in,
	output logic      sync_out
);

	logic meta_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_ff  <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta_ff  <= async_in;
			sync_out <= meta_ff;
		end
	end

endmodule : bertei_sync2

// file: logic/bertei_rate_gen.sv
// Decade-rate error scheduler for the transmit stream.
// Assumes one insertion opportunity per transmit bit, on pclk.
`timescale 1ns/1ps

module bertei_rate_gen
	import bertei_pkg::*;
(
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Configuration
	input  wire logic       rate_write,
	input  wire logic [2:0] rate_value,
	// Stream
	input  wire logic       bit_slot,
	output logic            rate_insert
);

	logic [2:0]  active_ff;
	logic [2:0]  pending_ff;
	logic [23:0] remain_ff;
	logic        running;

	assign running     = (active_ff != 3'h0);
	assign rate_insert = running && bit_slot && (remain_ff == CNT_ONE); // R04

	// A new rate waits in pending until the error in flight is inserted.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_ff  <= 3'h0;
			pending_ff <= 3'h0;
			remain_ff  <= CNT_ZERO;
		end else begin
			if (rate_write) begin
				pending_ff <= rate_value;
			end
			if (!running) begin
				if (rate_write && rate_value != 3'h0) begin // R05
					active_ff <= rate_value;
					remain_ff <= bertei_interval(rate_value);
				end
			end else if (rate_insert) begin // R06
				active_ff <= rate_write ? rate_value : pending_ff;
				remain_ff <= bertei_interval(rate_write ? rate_value : pending_ff);
			end else if (bit_slot) begin
				remain_ff <= remain_ff - CNT_ONE;
			end
		end
	end

endmodule : bertei_rate_gen

// file: logic/bertei_top.sv
// Error insertion, pattern word and checker status block of the bit error tester.
// Assumes an APB master on pclk, and transmit/receive bit slots, checker events
// and the global update and port interrupt enables coming from logic on pclk.
`timescale 1ns/1ps

module bertei_top
	import bertei_pkg::*;
(
	// APB slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Transmit stream
	input  wire logic        tx_bit_slot,
	input  wire logic        tx_bit_in,
	input  wire logic        tx_pattern_mode,
	input  wire logic        tx_pattern_load,
	output logic             tx_bit_out,
	output logic             tx_bit_valid,
	// Receive pattern reference
	input  wire logic        rx_bit_slot,
	input  wire logic        rx_pattern_load,
	output logic             rx_expected_bit,
	// External single error insert pin
	input  wire logic        external_insert_input,
	// Checker and counter side
	input  wire logic        checker_bit_error,
	input  wire logic        checker_sync_loss,
	input  wire logic        counter_update_done,
	input  wire logic        global_update_trigger,
	input  wire logic        port_status_irq_en,
	output logic             counter_update_req,
	output logic      [31:0] seed_pattern_word,
	output logic             irq_request
);

	// ------------------------------------------------------------------
	// Register bus decode
	// ------------------------------------------------------------------

	logic [9:0]  idx;
	logic        setup_phase;
	logic        wr_en;
	logic        mapped;
	logic [31:0] rd_mux;

	logic [15:0] seed_lo_ff;
	logic [15:0] seed_hi_ff;
	logic [5:0]  ins_ctrl_ff;
	logic [1:0]  upd_ctrl_ff;
	bertei_evt_t irq_en_ff;
	bertei_evt_t latched_ff;
	bertei_evt_t status;

	assign idx         = paddr[11:2];
	assign setup_phase = psel && !penable;
	assign wr_en       = psel && penable && pwrite;
	assign pready      = 1'b1;

	always_comb begin
		mapped = 1'b1;
		rd_mux = 32'h00000000;
		case (idx)
			IDX_SEED_LO:  rd_mux = {16'h0000, seed_lo_ff};
			IDX_SEED_HI:  rd_mux = {16'h0000, seed_hi_ff};
			IDX_INS_CTRL: rd_mux = {26'h0, ins_ctrl_ff};
			IDX_STATUS:   rd_mux = {28'h0000000, status};
			IDX_LATCHED:  rd_mux = {28'h0000000, latched_ff};
			IDX_IRQ_EN:   rd_mux = {28'h0000000, irq_en_ff};
			IDX_UPD_CTRL: rd_mux = {30'h0, upd_ctrl_ff};
			default:      mapped = 1'b0;
		endcase
	end

	// Read data and error are captured in the setup cycle so that both leave
	// flip-flops and stand steady through the single access cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (setup_phase) begin
			prdata  <= pwrite ? 32'h00000000 : rd_mux;
			pslverr <= !mapped;
		end
	end

	// ------------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------------

	logic ins_write;

	assign ins_write = wr_en && (idx == IDX_INS_CTRL);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seed_lo_ff <= RST_HALF; // R22
			seed_hi_ff <= RST_HALF; // R22
		end else if (wr_en) begin
			if (idx == IDX_SEED_LO) begin
				seed_lo_ff <= pwdata[15:0]; // R01
			end
			if (idx == IDX_SEED_HI) begin
				seed_hi_ff <= pwdata[15:0]; // R01
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ins_ctrl_ff <= 6'h00; // R22
		end else if (ins_write) begin
			ins_ctrl_ff <= pwdata[5:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			upd_ctrl_ff <= 2'h0; // R22
		end else if (wr_en && idx == IDX_UPD_CTRL) begin
			upd_ctrl_ff <= pwdata[1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_en_ff <= EVT_NONE; // R22
		end else if (wr_en && idx == IDX_IRQ_EN) begin
			irq_en_ff <= bertei_evt_t'(pwdata[3:0]);
		end
	end

	assign seed_pattern_word = {seed_hi_ff, seed_lo_ff}; // R01

	// ------------------------------------------------------------------
	// Pattern word serialisation
	// ------------------------------------------------------------------

	logic [31:0] tx_pat_ff;
	logic [31:0] rx_pat_ff;

	// Both shifters rotate left so bit 31 of the word is always the next bit.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_pat_ff <= 32'h00000000;
		end else if (tx_pattern_load) begin
			tx_pat_ff <= seed_pattern_word; // R02
		end else if (tx_bit_slot) begin
			tx_pat_ff <= {tx_pat_ff[30:0], tx_pat_ff[31]}; // R02
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_pat_ff <= 32'h00000000;
		end else if (rx_pattern_load) begin
			rx_pat_ff <= seed_pattern_word; // R03
		end else if (rx_bit_slot) begin
			rx_pat_ff <= {rx_pat_ff[30:0], rx_pat_ff[31]}; // R03
		end
	end

	assign rx_expected_bit = rx_pat_ff[31]; // R03

	// ------------------------------------------------------------------
	// Error insertion
	// ------------------------------------------------------------------

	logic ext_sync;
	logic single_src;
	logic single_src_ff;
	logic single_pend_ff;
	logic rate_insert;
	logic do_insert;
	logic tx_src_bit;

	bertei_sync2 u_ext_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (external_insert_input),
		.sync_out (ext_sync)
	);

	bertei_rate_gen u_rate (
		.pclk        (pclk),
		.presetn     (presetn),
		.rate_write  (ins_write),
		.rate_value  (pwdata[POS_RATE_LSB +: 3]),
		.bit_slot    (tx_bit_slot),
		.rate_insert (rate_insert)
	);

	// The edge detector follows the selected source, so flipping the select
	// onto a high trigger while the other is low looks like an edge; software avoids that.
	assign single_src = ins_ctrl_ff[POS_MANUAL_SEL] ? ext_sync // R10 R11
	                                                : ins_ctrl_ff[POS_SINGLE_TRIG];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			single_src_ff <= 1'b0;
		end else begin
			single_src_ff <= single_src;
		end
	end

	// One pending flag absorbs any number of edges until the next bit slot.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			single_pend_ff <= 1'b0;
		end else if (!ins_ctrl_ff[POS_SINGLE_EN]) begin
			single_pend_ff <= 1'b0; // R07
		end else if (single_src && !single_src_ff) begin
			single_pend_ff <= 1'b1; // R08 R09
		end else if (tx_bit_slot) begin
			single_pend_ff <= 1'b0; // R09
		end
	end

	assign do_insert  = tx_bit_slot && (rate_insert || single_pend_ff); // R04 R08
	assign tx_src_bit = tx_pattern_mode ? tx_pat_ff[31] : tx_bit_in; // R02

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_bit_out   <= 1'b0;
			tx_bit_valid <= 1'b0;
		end else begin
			tx_bit_valid <= tx_bit_slot;
			if (tx_bit_slot) begin
				tx_bit_out <= tx_src_bit ^ do_insert; // R04 R08
			end
		end
	end

	// ------------------------------------------------------------------
	// Counter update handshake
	// ------------------------------------------------------------------

	logic upd_trigger;
	logic upd_trigger_ff;
	logic upd_done_ff;

	assign upd_trigger = upd_ctrl_ff[POS_UPD_MODE] ? global_update_trigger // R19
	                                               : upd_ctrl_ff[POS_LOCAL_UPD];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			upd_trigger_ff     <= 1'b0;
			counter_update_req <= 1'b0;
		end else begin
			upd_trigger_ff     <= upd_trigger;
			counter_update_req <= upd_trigger && !upd_trigger_ff; // R19
		end
	end

	// Completion stays high until the trigger that asked for it is released.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			upd_done_ff <= 1'b0;
		end else if (!upd_trigger) begin
			upd_done_ff <= 1'b0; // R12
		end else if (counter_update_done) begin
			upd_done_ff <= 1'b1; // R12
		end
	end

	// ------------------------------------------------------------------
	// Checker status
	// ------------------------------------------------------------------

	logic count_nz_ff;
	logic sync_loss_ff;

	// Errors are not counted while out of sync, so they do not set this bit.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_nz_ff <= 1'b0;
		end else if (counter_update_done) begin
			count_nz_ff <= 1'b0; // R13
		end else if (checker_bit_error && !checker_sync_loss) begin
			count_nz_ff <= 1'b1; // R13
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_loss_ff <= 1'b0;
		end else begin
			sync_loss_ff <= checker_sync_loss; // R14
		end
	end

	assign status.update_done   = upd_done_ff;
	assign status.bit_error     = 1'b0;
	assign status.count_nonzero = count_nz_ff;
	assign status.sync_loss     = sync_loss_ff;

	// ------------------------------------------------------------------
	// Latched events and interrupt request
	// ------------------------------------------------------------------

	bertei_evt_t status_prev_ff;
	bertei_evt_t evt_set;
	bertei_evt_t evt_clr;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_prev_ff <= EVT_NONE;
		end else begin
			status_prev_ff <= status;
		end
	end

	assign evt_set.update_done   = status.update_done && !status_prev_ff.update_done; // R15
	assign evt_set.bit_error     = checker_bit_error; // R16
	assign evt_set.count_nonzero = status.count_nonzero && !status_prev_ff.count_nonzero; // R17
	assign evt_set.sync_loss     = status.sync_loss != status_prev_ff.sync_loss; // R18

	assign evt_clr = (wr_en && idx == IDX_LATCHED) ? bertei_evt_t'(pwdata[3:0]) : EVT_NONE;

	// A set arriving with its clear keeps the flag set.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latched_ff <= EVT_NONE;
		end else begin
			latched_ff <= (latched_ff & ~evt_clr) | evt_set; // R21
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_request <= 1'b0;
		end else begin
			irq_request <= (latched_ff.update_done && irq_en_ff.update_done) || // R20
			               (port_status_irq_en &&
			                |({latched_ff.bit_error, latched_ff.count_nonzero,
			                   latched_ff.sync_loss} &
			                  {irq_en_ff.bit_error, irq_en_ff.count_nonzero,
			                   irq_en_ff.sync_loss}));
		end
	end

endmodule : bertei_top

// file: bench/bertei_properties.sv
// Concurrent checks on the ports of the error insertion and status block.
// Assumes it is bound into bertei_top and sees only its ports.
`timescale 1ns/1ps

module bertei_properties
	import bertei_pkg::*;
(
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	// Streams and status
	input wire logic        tx_bit_slot,
	input wire logic        tx_bit_out,
	input wire logic        tx_bit_valid,
	input wire logic        rx_pattern_load,
	input wire logic        rx_expected_bit,
	input wire logic        checker_sync_loss,
	input wire logic        counter_update_req,
	input wire logic [31:0] seed_pattern_word
);
	logic [9:0] idx;
	logic       setup;
	logic       mapped;
	assign idx = paddr[11:2];
	assign setup = psel && !penable;
	assign mapped = idx inside {IDX_SEED_LO, IDX_SEED_HI, IDX_INS_CTRL, IDX_STATUS,
		IDX_LATCHED, IDX_IRQ_EN, IDX_UPD_CTRL};
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	seed_hi_a: assert property (psel && penable && pwrite && idx == IDX_SEED_HI
		|=> seed_pattern_word[31:16] == $past(pwdata[15:0])) else $error("upper seed wrong");
	seed_lo_a: assert property (psel && penable && pwrite && idx == IDX_SEED_LO
		|=> seed_pattern_word[15:0] == $past(pwdata[15:0])) else $error("lower seed wrong");
	rx_align_a: assert property (rx_pattern_load
		|=> rx_expected_bit == seed_pattern_word[31]) else $error("rx first bit wrong");
	sync_status_a: assert property (($stable(checker_sync_loss))[*4] ##0
		(setup && !pwrite && idx == IDX_STATUS) |=> prdata[0] == checker_sync_loss)
		else $error("sync status wrong");
	valid_follow_a: assert property (tx_bit_slot |=> tx_bit_valid)
		else $error("tx valid missing");
	valid_idle_a: assert property (!tx_bit_slot |=> !tx_bit_valid)
		else $error("tx valid without slot");
	out_hold_a: assert property (!tx_bit_slot |=> $stable(tx_bit_out))
		else $error("tx bit moved without slot");
	upd_pulse_a: assert property (counter_update_req |=> !counter_update_req)
		else $error("update request too long");
	bad_index_a: assert property (setup && !mapped |=> pslverr && prdata == 32'h00000000)
		else $error("unmapped access accepted");
endmodule : bertei_properties

bind bertei_top bertei_properties bertei_properties_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
	.tx_bit_slot(tx_bit_slot), .tx_bit_out(tx_bit_out), .tx_bit_valid(tx_bit_valid),
	.rx_pattern_load(rx_pattern_load), .rx_expected_bit(rx_expected_bit),
	.checker_sync_loss(checker_sync_loss), .counter_update_req(counter_update_req),
	.seed_pattern_word(seed_pattern_word));

// file: bench/bertei_framer_model.sv
// Framer side of the transmit stream: offers one bit a cycle while run is high.
// Counts bits that come back inverted and keeps the last 32 bits sent.
`timescale 1ns/1ps

module bertei_framer_model (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Control
	input  wire logic        run,
	// Transmit stream
	input  wire logic        tx_bit_valid,
	input  wire logic        tx_bit_out,
	output logic             tx_bit_slot,
	output logic             tx_bit_in,
	// Observation
	output int               err_cnt,
	output logic      [31:0] out_word
);
	logic sent_ff;

	// The data bit toggles every cycle, so an idle line never looks like the last bit.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_bit_slot <= 1'b0;
			tx_bit_in   <= 1'b0;
			sent_ff     <= 1'b0;
		end else begin
			tx_bit_slot <= run;
			tx_bit_in   <= ~tx_bit_in;
			if (tx_bit_slot) sent_ff <= tx_bit_in;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_cnt  <= 0;
			out_word <= 32'h00000000;
		end else if (tx_bit_valid) begin
			out_word <= {out_word[30:0], tx_bit_out};
			if (tx_bit_out !== sent_ff) err_cnt <= err_cnt + 1;
		end
	end
endmodule : bertei_framer_model

// file: bench/tb.sv
// Self-checking bench: APB register tasks, framer model on the transmit side,
// checker and counter events driven directly.
`timescale 1ns/1ps

`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
	$display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end

module tb;
	import bertei_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, prdata, seed_pattern_word, out_word;
	logic pready, pslverr, tx_bit_slot, tx_bit_in, tx_bit_out, tx_bit_valid;
	logic tx_pattern_mode = 0, tx_pattern_load = 0, rx_bit_slot = 0, rx_pattern_load = 0;
	logic ext_in = 0, bit_err = 0, sync_loss = 0, upd_done = 0, glob = 0, port_en = 0;
	logic rx_expected_bit, counter_update_req, irq_request, run = 0;
	int failures = 0, cmp_count = 0, cyc = 0, req_cnt = 0, err_cnt, base, p;
	logic [31:0] rd;
	logic er;

	always #50 pclk = ~pclk;

	bertei_top bertei_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_bit_slot(tx_bit_slot),
		.tx_bit_in(tx_bit_in), .tx_pattern_mode(tx_pattern_mode),
		.tx_pattern_load(tx_pattern_load), .tx_bit_out(tx_bit_out),
		.tx_bit_valid(tx_bit_valid), .rx_bit_slot(rx_bit_slot),
		.rx_pattern_load(rx_pattern_load), .rx_expected_bit(rx_expected_bit),
		.external_insert_input(ext_in), .checker_bit_error(bit_err),
		.checker_sync_loss(sync_loss), .counter_update_done(upd_done),
		.global_update_trigger(glob), .port_status_irq_en(port_en),
		.counter_update_req(counter_update_req), .seed_pattern_word(seed_pattern_word),
		.irq_request(irq_request));

	bertei_framer_model bertei_framer_model_i (.pclk(pclk), .presetn(presetn), .run(run),
		.tx_bit_valid(tx_bit_valid), .tx_bit_out(tx_bit_out), .tx_bit_slot(tx_bit_slot),
		.tx_bit_in(tx_bit_in), .err_cnt(err_cnt), .out_word(out_word));

	// The ceiling sits well above the longest decade-rate window.
	always @(posedge pclk) begin
		cyc++;
		if (counter_update_req === 1'b1) req_cnt++;
		if (cyc == 60000) begin
			failures++;
			results();
		end
	end

	task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the bench timeout ends a wait for the answer.
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
		apb(1'b1, idx, wd);
	endtask : wr

	task automatic rdchk(input logic [9:0] idx, input logic [15:0] exp);
		apb(1'b0, idx, 32'h00000000);
		`CHK(rd[15:0], exp)
	endtask : rdchk

	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask : tick

	// The first count covers errors inserted from the write edge on: it holds the
	// pending error of the old rate, so a rate that restarts at once shows up here.
	task automatic window(input int w, input int len, input int pre, input int exp);
		tick(2);
		base = err_cnt;
		tick(w - 2);
		`CHK(err_cnt - base, pre)
		base = err_cnt;
		tick(len);
		`CHK(err_cnt - base, exp)
	endtask : window

	task automatic since(input int exp);
		tick(6);
		`CHK(err_cnt - base, exp)
	endtask : since

	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : results

	initial begin
		tick(10);
		presetn <= 1'b1;
		rdchk(IDX_SEED_LO, 16'h0000);
		rdchk(IDX_SEED_HI, 16'h0000);
		rdchk(IDX_INS_CTRL, 16'h0000);
		rdchk(IDX_IRQ_EN, 16'h0000);
		rdchk(IDX_UPD_CTRL, 16'h0000);
		apb(1'b0, 10'h3FF, 32'h00000000);
		`CHK(er, 1'b1)
		`CHK(irq_request, 1'b0)
		$display("test reset done");
		wr(IDX_SEED_HI, 32'h0000A5C3);
		wr(IDX_SEED_LO, 32'h00001234);
		tick(1);
		`CHK(seed_pattern_word, 32'hA5C31234)
		rx_pattern_load <= 1'b1;
		tick(1);
		rx_pattern_load <= 1'b0;
		for (int i = 31; i >= 28; i--) begin
			tick(1);
			`CHK(rx_expected_bit, seed_pattern_word[i])
			rx_bit_slot <= 1'b1;
			tick(1);
			rx_bit_slot <= 1'b0;
		end
		tx_pattern_mode <= 1'b1;
		tx_pattern_load <= 1'b1;
		tick(1);
		tx_pattern_load <= 1'b0;
		run <= 1'b1;
		tick(32);
		run <= 1'b0;
		tick(4);
		`CHK(out_word, 32'hA5C31234)
		tx_pattern_mode <= 1'b0;
		run <= 1'b1;
		$display("test pattern done");
		p = 10;
		for (int n = 1; n <= 4; n++) begin
			wr(IDX_INS_CTRL, 32'(n << 3));
			window(p / 10 + 5, 2 * p, (n > 1) ? 1 : 0, 2);
			p = p * 10;
		end
		wr(IDX_INS_CTRL, 32'h00000000);
		window(p / 10 + 5, 1000, 1, 0);
		$display("test rate done");
		base = err_cnt;
		wr(IDX_INS_CTRL, 32'h00000002);
		wr(IDX_INS_CTRL, 32'h00000000);
		since(0);
		wr(IDX_INS_CTRL, 32'h00000004);
		base = err_cnt;
		for (int i = 0; i < 4; i++) wr(IDX_INS_CTRL, (i % 2) ? 32'h4 : 32'h6);
		since(2);
		run <= 1'b0;
		tick(3);
		base = err_cnt;
		for (int i = 0; i < 4; i++) wr(IDX_INS_CTRL, (i % 2) ? 32'h4 : 32'h6);
		run <= 1'b1;
		since(1);
		wr(IDX_INS_CTRL, 32'h00000005);
		base = err_cnt;
		ext_in <= 1'b1;
		tick(5);
		ext_in <= 1'b0;
		wr(IDX_INS_CTRL, 32'h00000007);
		wr(IDX_INS_CTRL, 32'h00000005);
		since(1);
		wr(IDX_INS_CTRL, 32'h00000000);
		$display("test single done");
		base = req_cnt;
		wr(IDX_UPD_CTRL, 32'h00000001);
		tick(3);
		`CHK(req_cnt - base, 1)
		upd_done <= 1'b1;
		tick(1);
		upd_done <= 1'b0;
		tick(3);
		rdchk(IDX_STATUS, 16'h0008);
		rdchk(IDX_LATCHED, 16'h0008);
		wr(IDX_IRQ_EN, 32'h00000008);
		tick(2);
		`CHK(irq_request, 1'b1)
		wr(IDX_LATCHED, 32'h00000000);
		rdchk(IDX_LATCHED, 16'h0008);
		wr(IDX_LATCHED, 32'h00000008);
		tick(2);
		`CHK(irq_request, 1'b0)
		wr(IDX_UPD_CTRL, 32'h00000000);
		rdchk(IDX_STATUS, 16'h0000);
		base = req_cnt;
		wr(IDX_UPD_CTRL, 32'h00000002);
		glob <= 1'b1;
		tick(3);
		wr(IDX_UPD_CTRL, 32'h00000003);
		tick(3);
		`CHK(req_cnt - base, 1)
		glob <= 1'b0;
		wr(IDX_UPD_CTRL, 32'h00000000);
		$display("test update done");
		sync_loss <= 1'b1;
		tick(4);
		rdchk(IDX_STATUS, 16'h0001);
		rdchk(IDX_LATCHED, 16'h0001);
		wr(IDX_LATCHED, 32'h00000001);
		sync_loss <= 1'b0;
		tick(4);
		rdchk(IDX_STATUS, 16'h0000);
		rdchk(IDX_LATCHED, 16'h0001);
		wr(IDX_LATCHED, 32'h00000001);
		bit_err <= 1'b1;
		tick(1);
		bit_err <= 1'b0;
		tick(4);
		rdchk(IDX_STATUS, 16'h0002);
		rdchk(IDX_LATCHED, 16'h0006);
		wr(IDX_IRQ_EN, 32'h00000007);
		tick(2);
		`CHK(irq_request, 1'b0)
		port_en <= 1'b1;
		tick(3);
		`CHK(irq_request, 1'b1)
		upd_done <= 1'b1;
		tick(1);
		upd_done <= 1'b0;
		tick(4);
		rdchk(IDX_STATUS, 16'h0000);
		wr(IDX_LATCHED, 32'h00000006);
		tick(3);
		`CHK(irq_request, 1'b0)
		$display("test status done");
		results();
	end
endmodule : tb
